// file: design/asps_sequencer.sv
`timescale 1ns/1ps
`include "asps_params.svh"

// ==========================================================
// Functional notes
// RULE1: the scan covers channels 00 to 63 carried as one 6-bit channel number.
// RULE2: the low three channel bits drive the first-level group member select.
// RULE3: the upper three channel bits drive the second-level group select.
// RULE4: the node discharge switch closes about 1.5 us and the new channel follows it.
// RULE5: gain lines come from the per-channel gain store in auto mode, else from straps.
// RULE6: two sample-and-hold stages alternate, one holding for conversion, one acquiring.
// RULE7: the two hold lines are always complementary and swap once per channel.
// RULE8: one convert command follows shortly after every hold swap.
// RULE9: after conversion a result-store strobe writes the word to the buffer slot.
// RULE10: each stored result is the 14-bit converter word.
// RULE11: at least 15 us passes from convert command to reading the result.
// RULE12: each channel cycle lasts 17 us, 2 us of it housekeeping; a store held by a bus access past 17 us stretches that cycle.
// RULE13: gain codes are 0 for x1, 1 for x10 and 2 for x100.
// RULE14: channels run upward from 00 and each result goes to its channel slot.
// RULE15: a store waits while a bus access to the buffer is in progress.
// RULE16: address and gain of the next channel are stable before its stage holds.
module asps_sequencer (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    scan_enable_i,
  input  wire logic [`ASPS_CHAN_W-1:0] last_chan_i,
  input  wire logic                    auto_gain_i,
  input  wire logic [`ASPS_GAIN_W-1:0] fixed_gain_i,
  input  wire logic                    gain_wr_i,
  input  wire logic [`ASPS_CHAN_W-1:0] gain_wr_chan_i,
  input  wire logic [`ASPS_GAIN_W-1:0] gain_wr_code_i,
  input  wire logic [`ASPS_DATA_W-1:0] adc_data_i,
  input  wire logic                    bus_busy_i,
  output logic [`ASPS_GRP_W-1:0]       group_member_select_o,
  output logic [`ASPS_GRP_W-1:0]       group_select_o,
  output logic                         gain_sel_bit0_o,
  output logic                         gain_sel_bit1_o,
  output logic                         mux_discharge_o,
  output logic                         hold_a_o,
  output logic                         hold_b_o,
  output logic                         adc_convert_o,
  output logic                         result_strobe_o,
  output logic [`ASPS_CHAN_W-1:0]      result_chan_o,
  output logic [`ASPS_DATA_W-1:0]      result_data_o,
  output logic                         scan_active_o
);

  // ==========================================================
  // state and storage
  asps_pkg::asps_state_t  state;
  asps_pkg::asps_state_t  next_state;
  asps_pkg::asps_sel_t    sel;
  asps_pkg::asps_sel_t    next_sel;
  asps_pkg::asps_result_t result;
  asps_pkg::asps_result_t next_result;

  logic [`ASPS_CHAN_W-1:0] mux_chan;
  logic [`ASPS_CHAN_W-1:0] pending_chan;
  logic [`ASPS_CHAN_W-1:0] held_chan;
  logic [`ASPS_CHAN_W-1:0] next_chan;
  logic [`ASPS_GAIN_W-1:0] gain_mem [`ASPS_NUM_CHAN];
  logic [`ASPS_GAIN_W-1:0] raw_gain;
  logic [`ASPS_GAIN_W-1:0] legal_gain;

  logic enter_swap;
  logic enter_prime;
  logic lag_done;
  logic dis_end;
  logic store_fire;
  logic cyc_done;
  logic conv_done;
  logic dis_done;
  logic cyc_load;
  logic conv_load;
  logic [`ASPS_TMR_W-1:0] conv_val;

  // ==========================================================
  // decode
  assign enter_swap  = (state != asps_pkg::ASPS_SWAP) && (next_state == asps_pkg::ASPS_SWAP);
  assign enter_prime = (state == asps_pkg::ASPS_IDLE) && (next_state == asps_pkg::ASPS_PRIME);
  assign lag_done    = (state == asps_pkg::ASPS_SWAP) && conv_done;
  assign dis_end     = mux_discharge_o && dis_done && !enter_swap;
  assign store_fire  = (state == asps_pkg::ASPS_STORE) && !bus_busy_i;   // see RULE15
  assign cyc_load    = enter_swap || enter_prime;
  assign conv_load   = enter_swap || lag_done;
  assign conv_val    = lag_done ? `ASPS_TMR_W'(`ASPS_CONV_CYC - 1)      // see RULE11
                                : `ASPS_TMR_W'(`ASPS_LAG_CYC - 1);
  // wrap at the end of the active block, ascending from 00
  assign next_chan   = (mux_chan >= last_chan_i) ? `ASPS_FIRST_CHAN     // see RULE14
                                                 : mux_chan + `ASPS_CHAN_STEP;
  assign raw_gain    = auto_gain_i ? gain_mem[pending_chan] : fixed_gain_i;   // see RULE5
  // the reserved code would leave the amplifier undefined, fall back to x1
  assign legal_gain  = (raw_gain == `ASPS_GAIN_RSVD) ? `ASPS_GAIN_X1 : raw_gain; // see RULE13
  assign next_sel    = '{grp:    pending_chan[`ASPS_CHAN_W-1:`ASPS_GRP_W],  // see RULE3
                         member: pending_chan[`ASPS_GRP_W-1:0],             // see RULE2
                         gain:   legal_gain};
  assign next_result = '{chan: held_chan, data: adc_data_i};             // see RULE10

  assign group_member_select_o = sel.member;
  assign group_select_o        = sel.grp;
  assign gain_sel_bit0_o       = sel.gain[0];
  assign gain_sel_bit1_o       = sel.gain[1];
  assign result_chan_o         = result.chan;
  assign result_data_o         = result.data;

  // ==========================================================
  // timers
  asps_timer #(.W(`ASPS_TMR_W)) u_cyc_tmr (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .load_i     (cyc_load),
    .load_val_i (`ASPS_TMR_W'(`ASPS_CYC_CYC - 1)),                     // see RULE12
    .done_o     (cyc_done)
  );

  asps_timer #(.W(`ASPS_TMR_W)) u_conv_tmr (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .load_i     (conv_load),
    .load_val_i (conv_val),
    .done_o     (conv_done)
  );

  asps_timer #(.W(`ASPS_TMR_W)) u_dis_tmr (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .load_i     (cyc_load),
    .load_val_i (`ASPS_TMR_W'(`ASPS_DIS_CYC - 1)),                     // see RULE4
    .done_o     (dis_done)
  );

  // ==========================================================
  // sequence
  always_comb begin
    next_state = state;
    case (state)
      asps_pkg::ASPS_IDLE: begin
        if (scan_enable_i) next_state = asps_pkg::ASPS_PRIME;
      end
      // first channel gets a full cycle of acquisition before it holds
      asps_pkg::ASPS_PRIME: begin
        if (cyc_done && !mux_discharge_o) next_state = asps_pkg::ASPS_SWAP;
      end
      asps_pkg::ASPS_SWAP: begin
        if (conv_done) next_state = asps_pkg::ASPS_CONV;                // see RULE8
      end
      asps_pkg::ASPS_CONV: begin
        if (conv_done) next_state = asps_pkg::ASPS_STORE;               // see RULE11
      end
      asps_pkg::ASPS_STORE: begin
        if (!bus_busy_i) next_state = asps_pkg::ASPS_PAD;               // see RULE15
      end
      // a stretched store leaves cyc_done already set: swap follows at once
      asps_pkg::ASPS_PAD: begin
        if (cyc_done) begin
          next_state = scan_enable_i ? asps_pkg::ASPS_SWAP : asps_pkg::ASPS_IDLE; // see RULE12
        end
      end
      default: next_state = asps_pkg::ASPS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state         <= asps_pkg::ASPS_IDLE;
      scan_active_o <= 1'b0;
      adc_convert_o <= 1'b0;
    end else begin
      state         <= next_state;
      scan_active_o <= (next_state != asps_pkg::ASPS_IDLE);
      adc_convert_o <= lag_done;                                         // see RULE8
    end
  end

  // both lines flip on the same edge so they never agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_a_o  <= 1'b0;
      hold_b_o  <= 1'b1;
      held_chan <= `ASPS_FIRST_CHAN;
    end else if (enter_swap) begin
      hold_a_o  <= !hold_a_o;                                            // see RULE7
      hold_b_o  <= !hold_b_o;                                            // see RULE6
      held_chan <= mux_chan;
    end
  end

  // address moves only when the discharge window closes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mux_discharge_o <= 1'b0;
      pending_chan    <= `ASPS_FIRST_CHAN;
      mux_chan        <= `ASPS_FIRST_CHAN;
      sel             <= '0;
    end else if (cyc_load) begin
      mux_discharge_o <= 1'b1;                                           // see RULE4
      pending_chan    <= enter_prime ? `ASPS_FIRST_CHAN : next_chan;     // see RULE1
    end else if (dis_end) begin
      mux_discharge_o <= 1'b0;
      mux_chan        <= pending_chan;                                   // see RULE4
      sel             <= next_sel;                                       // see RULE16
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_strobe_o <= 1'b0;
      result          <= '0;
    end else begin
      result_strobe_o <= store_fire;                                     // see RULE9
      if (store_fire) result <= next_result;                             // see RULE14
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `ASPS_NUM_CHAN; i++) gain_mem[i] <= `ASPS_GAIN_X1;
    end else if (gain_wr_i) begin
      gain_mem[gain_wr_chan_i] <= gain_wr_code_i;                        // see RULE5
    end
  end

  // ==========================================================
  // checks
  localparam int CHK_LAG  = `ASPS_LAG_CYC;
  localparam int CHK_CONV = `ASPS_CONV_CYC;
  localparam int CHK_CYC  = `ASPS_CYC_CYC;
  localparam int CHK_DIS  = `ASPS_DIS_CYC;

  logic [`ASPS_TMR_W-1:0]  since_conv;
  logic [`ASPS_TMR_W-1:0]  since_swap;
  logic [`ASPS_DLEN_W-1:0] dis_len;
  logic                    hold_prev;
  logic                    swapped_once;
  logic                    stored_once;
  logic [`ASPS_CHAN_W-1:0] last_stored;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_conv   <= '1;
      since_swap   <= '0;
      dis_len      <= '0;
      hold_prev    <= 1'b0;
      swapped_once <= 1'b0;
      stored_once  <= 1'b0;
      last_stored  <= `ASPS_FIRST_CHAN;
    end else begin
      since_conv   <= adc_convert_o ? '0 : ((since_conv == '1) ? since_conv : since_conv + 1'b1);
      since_swap   <= (hold_a_o != hold_prev) ? '0 :
                      ((since_swap == '1) ? since_swap : since_swap + 1'b1);
      dis_len      <= mux_discharge_o ? dis_len + 1'b1 : '0;
      hold_prev    <= hold_a_o;
      swapped_once <= swapped_once || (hold_a_o != hold_prev);
      stored_once  <= stored_once || result_strobe_o;
      if (result_strobe_o) last_stored <= result_chan_o;
    end
  end

  chk_hold_complement: assert property (  // see RULE7
    @(posedge clk_i) disable iff (!resetn_i) hold_a_o != hold_b_o)
    else $error("hold lines not complementary");

  chk_swap_to_convert: assert property (  // see RULE8
    @(posedge clk_i) disable iff (!resetn_i)
    $changed(hold_a_o) |-> !adc_convert_o ##[CHK_LAG:CHK_LAG] adc_convert_o)
    else $error("convert command not at fixed lag after hold swap");

  chk_convert_single: assert property (  // see RULE8
    @(posedge clk_i) disable iff (!resetn_i) adc_convert_o |=> !adc_convert_o)
    else $error("convert command longer than one cycle");

  chk_conv_wait: assert property (  // see RULE11
    @(posedge clk_i) disable iff (!resetn_i) result_strobe_o |-> since_conv >= CHK_CONV)
    else $error("result stored before conversion time elapsed");

  chk_store_not_busy: assert property (  // see RULE15
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(result_strobe_o) |-> !$past(bus_busy_i) && $past(state) == asps_pkg::ASPS_STORE)
    else $error("store taken during bus access");

  chk_discharge_len: assert property (  // see RULE4
    @(posedge clk_i) disable iff (!resetn_i) $fell(mux_discharge_o) |-> dis_len == CHK_DIS)
    else $error("discharge window length wrong");

  chk_addr_during_dis: assert property (  // see RULE4
    @(posedge clk_i) disable iff (!resetn_i)
    mux_discharge_o && $past(mux_discharge_o) |-> $stable(sel))
    else $error("channel changed inside discharge window");

  chk_sel_before_hold: assert property (  // see RULE16
    @(posedge clk_i) disable iff (!resetn_i)
    $changed(hold_a_o) |-> $stable(sel) && !$past(mux_discharge_o))
    else $error("selection not settled at hold");

  chk_cycle_period: assert property (  // see RULE12
    @(posedge clk_i) disable iff (!resetn_i)
    (hold_a_o != hold_prev) && swapped_once |-> since_swap >= CHK_CYC - 1)
    else $error("channel cycle shorter than period");

  chk_chan_ascend: assert property (  // see RULE14
    @(posedge clk_i) disable iff (!resetn_i)
    result_strobe_o && stored_once |->
      result_chan_o == `ASPS_FIRST_CHAN || result_chan_o == last_stored + `ASPS_CHAN_STEP)
    else $error("stored channel out of order");

  chk_gain_legal: assert property (  // see RULE13
    @(posedge clk_i) disable iff (!resetn_i) sel.gain != `ASPS_GAIN_RSVD)
    else $error("reserved gain code driven");

endmodule // asps_sequencer

// file: design/asps_timer.sv
`timescale 1ns/1ps
`include "asps_params.svh"

// ==========================================================
// loadable down counter, done holds at zero
module asps_timer #(
  parameter int W = `ASPS_TMR_W
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              done_o
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign next_count = load_i ? load_val_i :
                      (count == '0) ? count : count - {{(W-1){1'b0}}, 1'b1};
  assign done_o     = (count == '0);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule // asps_timer

// file: inc/asps_params.svh
`ifndef ASPS_PARAMS_SVH
`define ASPS_PARAMS_SVH

// ==========================================================
// widths
`define ASPS_CHAN_W      6
`define ASPS_GRP_W       3
`define ASPS_DATA_W      14
`define ASPS_GAIN_W      2
`define ASPS_TMR_W       10
`define ASPS_DLEN_W      7
`define ASPS_NUM_CHAN    64

// ==========================================================
// channel numbering and gain codes
`define ASPS_FIRST_CHAN  6'h00
`define ASPS_CHAN_STEP   6'h01
`define ASPS_GAIN_X1     2'h0
`define ASPS_GAIN_X10    2'h1
`define ASPS_GAIN_X100   2'h2
`define ASPS_GAIN_RSVD   2'h3

// ==========================================================
// timing, times in ns as printed, cycle counts derived
`define ASPS_CLK_NS        20
`define ASPS_DISCHARGE_NS  1500
`define ASPS_CONV_NS       15000
`define ASPS_CYCLE_NS      17000
`define ASPS_HOUSEKEEP_NS  2000
`define ASPS_CONV_LAG_NS   100
`define ASPS_DIS_CYC  ((`ASPS_DISCHARGE_NS + `ASPS_CLK_NS - 1) / `ASPS_CLK_NS)
`define ASPS_CONV_CYC ((`ASPS_CONV_NS + `ASPS_CLK_NS - 1) / `ASPS_CLK_NS)
`define ASPS_CYC_CYC  ((`ASPS_CYCLE_NS + `ASPS_CLK_NS - 1) / `ASPS_CLK_NS)
`define ASPS_LAG_CYC  ((`ASPS_CONV_LAG_NS + `ASPS_CLK_NS - 1) / `ASPS_CLK_NS)

`endif

// file: inc/asps_pkg.sv
`include "asps_params.svh"

package asps_pkg;

  // gray codes along idle-prime-swap-conv-store-pad-swap
  typedef enum logic [2:0] {
    ASPS_IDLE  = 3'h0,
    ASPS_PRIME = 3'h1,
    ASPS_SWAP  = 3'h3,
    ASPS_CONV  = 3'h2,
    ASPS_STORE = 3'h6,
    ASPS_PAD   = 3'h7
  } asps_state_t;

  typedef struct packed {
    logic [`ASPS_GRP_W-1:0]  grp;
    logic [`ASPS_GRP_W-1:0]  member;
    logic [`ASPS_GAIN_W-1:0] gain;
  } asps_sel_t;

  typedef struct packed {
    logic [`ASPS_CHAN_W-1:0] chan;
    logic [`ASPS_DATA_W-1:0] data;
  } asps_result_t;

endpackage

// file: verification/adc_scan_pipeline_sequencer_bench.sv
`timescale 1ns/1ps
`include "asps_params.svh"

module adc_scan_pipeline_sequencer_bench;
  logic                    clk_i = 1'b0;
  logic                    resetn_i = 1'b0;
  logic                    scan_enable_i = 1'b0;
  logic                    auto_gain_i = 1'b0;
  logic                    gain_wr_i = 1'b0;
  logic                    bus_busy_i = 1'b0;
  logic [`ASPS_CHAN_W-1:0] last_chan_i = 6'h00;
  logic [`ASPS_CHAN_W-1:0] gain_wr_chan_i = 6'h00;
  logic [`ASPS_GAIN_W-1:0] fixed_gain_i = 2'h0;
  logic [`ASPS_GAIN_W-1:0] gain_wr_code_i = 2'h0;
  logic [`ASPS_DATA_W-1:0] adc_data_i;
  logic [`ASPS_GRP_W-1:0]  group_member_select_o;
  logic [`ASPS_GRP_W-1:0]  group_select_o;
  logic                    gain_sel_bit0_o, gain_sel_bit1_o, mux_discharge_o;
  logic                    hold_a_o, hold_b_o, adc_convert_o, result_strobe_o, scan_active_o;
  logic [`ASPS_CHAN_W-1:0] result_chan_o;
  logic [`ASPS_DATA_W-1:0] result_data_o;
  logic [`ASPS_GAIN_W-1:0] gain_store [64];
  int                      error_cnt = 0;
  int                      checks = 0;
  int                      cycles = 0;

  asps_sequencer u_asps_sequencer (
    .clk_i(clk_i), .resetn_i(resetn_i), .scan_enable_i(scan_enable_i),
    .last_chan_i(last_chan_i), .auto_gain_i(auto_gain_i), .fixed_gain_i(fixed_gain_i),
    .gain_wr_i(gain_wr_i), .gain_wr_chan_i(gain_wr_chan_i), .gain_wr_code_i(gain_wr_code_i),
    .adc_data_i(adc_data_i), .bus_busy_i(bus_busy_i),
    .group_member_select_o(group_member_select_o), .group_select_o(group_select_o),
    .gain_sel_bit0_o(gain_sel_bit0_o), .gain_sel_bit1_o(gain_sel_bit1_o),
    .mux_discharge_o(mux_discharge_o), .hold_a_o(hold_a_o), .hold_b_o(hold_b_o),
    .adc_convert_o(adc_convert_o), .result_strobe_o(result_strobe_o),
    .result_chan_o(result_chan_o), .result_data_o(result_data_o),
    .scan_active_o(scan_active_o)
  );

  asps_analog_model u_asps_analog_model (
    .clk_i(clk_i), .resetn_i(resetn_i), .group_select_i(group_select_o),
    .group_member_select_i(group_member_select_o), .hold_a_i(hold_a_o),
    .adc_convert_i(adc_convert_o), .adc_data_o(adc_data_i)
  );

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ==========================================================
  // reporting
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // full run is about 77k cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==========================================================
  // one channel, entered at the negedge that shows its hold swap
  task automatic chan_cycle(input logic [5:0] ch, input logic [1:0] g, input bit stall,
                            input bit fin);
    int n, conv_n, conv_cnt, dis_n, str_n, str_cnt;
    logic lh;
    check(hold_a_o, {~hold_b_o}, "hold lines complementary");
    check({group_select_o, group_member_select_o}, ch, "held address");
    check({gain_sel_bit1_o, gain_sel_bit0_o}, g, "held gain");
    check(mux_discharge_o, 1'b1, "discharge at swap");
    lh = hold_a_o;
    n = 0;
    conv_n = 0;
    conv_cnt = 0;
    dis_n = 0;
    str_n = 0;
    str_cnt = 0;
    while (n < 1000) begin
      @(negedge clk_i);
      n++;
      if (hold_a_o !== lh) break;
      if (stall && n == 700) bus_busy_i = 1'b1;
      // held past the cycle end so the store stretches the channel cycle
      if (stall && n == 900) bus_busy_i = 1'b0;
      if (fin && n == 100) scan_enable_i = 1'b0;
      if (adc_convert_o === 1'b1) begin
        conv_cnt++;
        conv_n = n;
      end
      if (mux_discharge_o === 1'b0 && dis_n == 0) dis_n = n;
      if (result_strobe_o === 1'b1) begin
        str_cnt++;
        str_n = n;
        check(result_chan_o, ch, "stored channel");
        check(result_data_o, {2'h2, ch, ~ch}, "stored word");
      end
    end
    check(conv_cnt, 1, "one convert per swap");
    check(conv_n, 5, "convert lag");
    check(dis_n, 75, "discharge length");
    check(str_cnt, 1, "one store strobe");
    check(str_n, stall ? 901 : 756, "store moment");
    check(n, fin ? 1000 : (stall ? str_n + 1 : 850), "channel period");
    if (fin) check(scan_active_o, 1'b0, "idle after disable");
  endtask

  task automatic scan_run(input logic auto, input logic [1:0] code, input logic [5:0] last,
                          input int count, input int stall_at);
    int k;
    logic lh;
    logic [5:0] ch;
    logic [1:0] g;
    fixed_gain_i = code;
    auto_gain_i = auto;
    last_chan_i = last;
    scan_enable_i = 1'b1;
    @(negedge clk_i);
    @(negedge clk_i);
    check(mux_discharge_o, 1'b1, "discharge after start");
    check(scan_active_o, 1'b1, "active after start");
    lh = hold_a_o;
    k = 1;
    while (hold_a_o === lh && k < 1000) begin
      @(negedge clk_i);
      k++;
    end
    check(k, 850, "first hold swap");
    for (int i = 0; i < count; i++) begin
      ch = 6'(i % (int'(last) + 1));
      g = auto ? gain_store[ch] : ((code == 2'h3) ? 2'h0 : code);
      chan_cycle(ch, g, i == stall_at, i == count - 1);
    end
  endtask

  task automatic load_gains();
    for (int i = 0; i < 4; i++) begin
      gain_wr_i = 1'b1;
      gain_wr_chan_i = 6'(i);
      gain_wr_code_i = 2'((i + 2) % 3);
      gain_store[i] = 2'((i + 2) % 3);
      @(negedge clk_i);
    end
    gain_wr_i = 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 64; i++) begin
      gain_store[i] = 2'h0;
    end
    repeat (9) @(negedge clk_i);
    check({hold_a_o, hold_b_o, mux_discharge_o, adc_convert_o}, 4'h4, "reset holds");
    check({result_strobe_o, scan_active_o, group_select_o, group_member_select_o}, 8'h00,
          "reset outputs");
    @(negedge clk_i);
    resetn_i = 1'b1;
    @(negedge clk_i);
    for (int c = 0; c < 4; c++) begin
      scan_run(1'b0, 2'(c), 6'h01, 3, -1);
    end
    load_gains();
    scan_run(1'b1, 2'h3, 6'h03, 6, 2);
    scan_run(1'b1, 2'h0, 6'h3F, 65, -1);
    complete_run();
  end
endmodule  // adc_scan_pipeline_sequencer_bench

// file: verification/asps_analog_model.sv
`timescale 1ns/1ps
`include "asps_params.svh"

// ==========================================================
// held stage and converter seen from the sequencer's pins
module asps_analog_model #(
  parameter int CONV_CYC = `ASPS_CONV_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic [`ASPS_GRP_W-1:0]  group_select_i,
  input  wire logic [`ASPS_GRP_W-1:0]  group_member_select_i,
  input  wire logic                    hold_a_i,
  input  wire logic                    adc_convert_i,
  output logic      [`ASPS_DATA_W-1:0] adc_data_o
);
  logic [`ASPS_CHAN_W-1:0] held_chan;
  logic [`ASPS_DATA_W-1:0] word;
  logic                    last_hold;
  int                      busy_cnt;

  // word tied to the held channel so a wrong pairing shows
  assign word = {2'h2, held_chan, ~held_chan};
  // no settled word mid-conversion, so show the inverse
  assign adc_data_o = (busy_cnt == 0) ? word : ~word;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      held_chan <= 6'h00;
      last_hold <= 1'b0;
      busy_cnt  <= 0;
    end else begin
      last_hold <= hold_a_i;
      // stage entering hold keeps the address acquired so far
      if (hold_a_i != last_hold) begin
        held_chan <= {group_select_i, group_member_select_i};
      end
      if (adc_convert_i) begin
        // the command's own edge is the first conversion cycle
        busy_cnt <= CONV_CYC - 1;
      end else if (busy_cnt > 0) begin
        busy_cnt <= busy_cnt - 1;
      end
    end
  end
endmodule  // asps_analog_model
